//--- measurement_trigger_control_tb_top.sv
// Self-checking testbench of the measurement trigger control block
`timescale 1ns/10ps
`default_nettype none
`include "mtc_consts.svh"
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
module measurement_trigger_control_tb_top;
  import mtc_pkg::*;
  logic             hclk = 1'b0;
  logic             hresetn, hsel, hwrite;
  logic [31:0]      haddr, hwdata, hrdata, q;
  logic [1:0]       htrans;
  logic [2:0]       hsize;
  logic             hreadyout, hresp, sync_trig_in, aux_trigger_input;
  logic [2:0][31:0] enc_pos;
  logic             cycle_start, exposure_end, record_en, output_en, trig_time_valid;
  logic [15:0]      trig_time_diff, g_diff;
  logic [16:0]      seed = 17'd91398;
  mtc_ctrl_t        ctrl;
  int               n_mismatch, check_count, cyc, n, g_rec, g_out, g_val, f_rec, f_out, f_val;

  always #2.5 hclk = ~hclk;

  mtc_trigger_ctrl DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .sync_trig_in(sync_trig_in), .aux_trigger_input(aux_trigger_input),
    .enc_pos(enc_pos), .cycle_start(cycle_start), .exposure_end(exposure_end), .record_en(record_en),
    .output_en(output_en), .trig_time_diff(trig_time_diff), .trig_time_valid(trig_time_valid));
  mtc_far_model far (.hclk(hclk), .sync_trig_in(sync_trig_in), .aux_trigger_input(aux_trigger_input),
    .enc_pos(enc_pos));

  function automatic logic [16:0] lfsr(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction

  task automatic final_report();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Ceiling is several times the expected run of about eight thousand clocks
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 50000) begin
      n_mismatch++;
      final_report();
    end
  end

  // Zero-wait slave, but the master still waits on hready
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= wr;
    hsize  <= 3'b010;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    `CHK(q, e)
    `CHK(hresp, 1'b0)
  endtask

  // Values seen at an edge are those launched together with cycle_start
  task automatic wait_cs();
    do @(posedge hclk); while (cycle_start !== 1'b1);
  endtask

  task automatic run_cycles(input int k);
    g_rec = 0; g_out = 0; g_val = 0; f_rec = -1; f_out = -1; f_val = -1;
    for (int i = 0; i < k; i++) begin
      wait_cs();
      if (record_en === 1'b1 && f_rec < 0) f_rec = i;
      if (output_en === 1'b1 && f_out < 0) f_out = i;
      if (trig_time_valid === 1'b1 && f_val < 0) g_diff = trig_time_diff;
      if (trig_time_valid === 1'b1 && f_val < 0) f_val = i;
      g_rec += int'(record_en === 1'b1);
      g_out += int'(output_en === 1'b1);
      g_val += int'(trig_time_valid === 1'b1);
    end
  endtask

  task automatic burst(input logic aux, input int clocks, input int k);
    ahb(1'b1, `MTC_OFF_CTRL, ctrl);
    run_cycles(2);
    fork
      far.pulse(aux, clocks);
      run_cycles(k);
    join
  endtask

  initial begin
    hresetn = 1'b0; hsel = 1'b0; haddr = '0; htrans = 2'b00; hwrite = 1'b0; hsize = 3'b010; hwdata = '0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    `CHK(record_en, 1'b1)
    `CHK(trig_time_valid, 1'b0)
    rd_chk(`MTC_OFF_CTRL, `MTC_CTRL_RST);
    rd_chk(`MTC_OFF_COUNT, `MTC_COUNT_RST);
    rd_chk(`MTC_OFF_PERIOD, `MTC_PERIOD_RST);
    rd_chk(`MTC_OFF_ENC_HIGH, `MTC_ENC_HIGH_RST);
    rd_chk(`MTC_OFF_ENC_STEP, `MTC_ENC_STEP_RST);
    seed = lfsr(seed);
    rd_chk(32'h40 + {seed[3:0], 2'b00}, 32'h0);
    ahb(1'b1, `MTC_OFF_PERIOD, 32'h40);
    wait_cs();
    wait_cs();
    n = 0;
    do begin @(posedge hclk); n++; end while (exposure_end !== 1'b1);
    `CHK(n, `MTC_EXP_OFFSET_CYC)
    wait_cs();
    n = 0;
    do begin @(posedge hclk); n++; end while (cycle_start !== 1'b1);
    `CHK(n, 64)
    run_cycles(4);
    `CHK(g_rec, 4)
    seed = lfsr(seed);
    n = 2 + int'(seed[1:0]);
    ahb(1'b1, `MTC_OFF_COUNT, n);
    ctrl = '0;
    ctrl.src = SRC_SW;
    ahb(1'b1, `MTC_OFF_CTRL, ctrl);
    run_cycles(2);
    ahb(1'b1, `MTC_OFF_CMD, 32'h1);
    run_cycles(n + 6);
    `CHK(g_rec, n)
    `CHK(g_out, n)
    `CHK(f_out - f_rec, `MTC_PROC_DLY - 1)
    // Infinite count runs past the programmed count until stopped
    ctrl.infinite = 1'b1;
    ahb(1'b1, `MTC_OFF_CTRL, ctrl);
    ahb(1'b1, `MTC_OFF_CMD, 32'h1);
    run_cycles(n + 3);
    `CHK(g_rec, n + 3)
    ahb(1'b1, `MTC_OFF_CMD, 32'h2);
    run_cycles(2);
    run_cycles(6);
    `CHK(g_rec, 0)
    ahb(1'b1, `MTC_OFF_COUNT, n);
    ctrl.infinite = 1'b0;
    ctrl.src = SRC_SYNC;
    ctrl.edge_mode = 1'b1;
    ctrl.pol_high = 1'b1;
    burst(1'b0, 1000, 20);
    `CHK(g_rec, n)
    `CHK(f_val - f_rec, `MTC_TTD_DLY - 1)
    `CHK(g_val, 1)
    `CHK(g_diff < 16'h6, 1'b1)
    // Falling edge: the burst starts when the pulse ends
    ctrl.mode_out = 1'b1;
    ctrl.pol_high = 1'b0;
    burst(1'b0, 1000, 24);
    `CHK(g_rec, 24)
    `CHK(g_out, n)
    ctrl = '0;
    ctrl.src = SRC_AUX;
    ctrl.pol_high = 1'b1;
    burst(1'b1, 1024, 20);
    `CHK(g_rec, 16)
    `CHK(g_out, 16)
    ahb(1'b1, `MTC_OFF_ENC_LOW, 32'd100);
    ahb(1'b1, `MTC_OFF_ENC_HIGH, 32'd200);
    ahb(1'b1, `MTC_OFF_ENC_STEP, 32'd50);
    ctrl.src = SRC_ENC0;
    ahb(1'b1, `MTC_OFF_CTRL, ctrl);
    run_cycles(2);
    fork
      far.ramp(300, 2);
      run_cycles(14);
    join
    `CHK(g_rec, 3)
    final_report();
  end
endmodule
`default_nettype wire

//--- mtc_consts.svh
// Constants of the measurement trigger control block
`ifndef MTC_CONSTS_SVH
`define MTC_CONSTS_SVH

`define MTC_ADDR_W          8
`define MTC_OFF_CTRL        8'h00
`define MTC_OFF_COUNT       8'h04
`define MTC_OFF_PERIOD      8'h08
`define MTC_OFF_CMD         8'h0C
`define MTC_OFF_ENC_LOW     8'h10
`define MTC_OFF_ENC_HIGH    8'h14
`define MTC_OFF_ENC_STEP    8'h18
`define MTC_OFF_STATUS      8'h1C
`define MTC_OFF_TTD         8'h20

`define MTC_CTRL_RST        32'h0000_0000
`define MTC_COUNT_RST       14'h0001
`define MTC_COUNT_ONE       14'h0001
`define MTC_COUNT_ZERO      14'h0000
`define MTC_PERIOD_RST      16'h8235
`define MTC_PERIOD_MIN      16'h0020
`define MTC_ENC_LOW_RST     32'h0000_0000
`define MTC_ENC_HIGH_RST    32'hFFFF_FFFF
`define MTC_ENC_STEP_RST    32'h0000_0001

`define MTC_CMD_START_BIT   0
`define MTC_CMD_STOP_BIT    1

`define MTC_CLK_PERIOD_NS   5
`define MTC_EXP_OFFSET_NS   100
`define MTC_EXP_OFFSET_CYC  ((`MTC_EXP_OFFSET_NS + `MTC_CLK_PERIOD_NS - 1) / `MTC_CLK_PERIOD_NS)
`define MTC_TRIG_MIN_NS     5000
`define MTC_PROC_DLY        2
`define MTC_TTD_DLY         5

`endif

//--- mtc_cycle_pipe.sv
// Shift pipeline that advances once per measuring cycle
`timescale 1ns/10ps
`default_nettype none
module mtc_cycle_pipe #(
  parameter int               WIDTH   = 1,
  parameter int               DEPTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset
  input  wire logic             hclk,
  input  wire logic             hresetn,
  // Data
  input  wire logic             adv,
  input  wire logic [WIDTH-1:0] din,
  output var  logic [WIDTH-1:0] dout
);
  logic [DEPTH-1:0][WIDTH-1:0] stage_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stage_r <= {DEPTH{RST_VAL}};
    end else if (adv) begin
      stage_r[0] <= din;
      for (int i = 1; i < DEPTH; i++) begin
        stage_r[i] <= stage_r[i-1];
      end
    end
  end

  assign dout = stage_r[DEPTH-1];
endmodule
`default_nettype wire

//--- mtc_far_model.sv
// Far-side model: trigger pins and encoder position source
`timescale 1ns/10ps
`default_nettype none
module mtc_far_model (
  // Clock
  input  wire logic             hclk,
  // Pins and positions toward the block
  output var  logic             sync_trig_in,
  output var  logic             aux_trigger_input,
  output var  logic [2:0][31:0] enc_pos
);
  initial begin
    sync_trig_in      = 1'b0;
    aux_trigger_input = 1'b0;
    enc_pos           = '0;
  end

  // Callers keep edge pulses >= 1000 clocks (5 us) and level pulses >= one cycle
  task automatic pulse(input logic aux, input int clocks);
    if (aux) begin
      aux_trigger_input <= 1'b1;
    end else begin
      sync_trig_in <= 1'b1;
    end
    repeat (clocks) @(posedge hclk);
    aux_trigger_input <= 1'b0;
    sync_trig_in      <= 1'b0;
  endtask

  // Positions only increase, one step per stride clocks
  task automatic ramp(input int last, input int stride);
    for (int p = 0; p <= last; p++) begin
      enc_pos[0] <= p[31:0];
      repeat (stride) @(posedge hclk);
    end
  endtask
endmodule
`default_nettype wire

//--- mtc_pkg.sv
// Types of the measurement trigger control block
package mtc_pkg;

  typedef enum logic [2:0] {
    SRC_INACT = 3'b000,
    SRC_SYNC  = 3'b001,
    SRC_AUX   = 3'b010,
    SRC_SW    = 3'b011,
    SRC_ENC0  = 3'b100,
    SRC_ENC1  = 3'b101,
    SRC_ENC2  = 3'b110
  } mtc_src_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_RUN  = 1'b1
  } mtc_state_t;

  typedef struct packed {
    logic [24:0] rsvd;
    logic        mode_out;
    logic        infinite;
    logic        pol_high;
    logic        edge_mode;
    mtc_src_t    src;
  } mtc_ctrl_t;

  typedef struct packed {
    logic [1:0]  rsvd_hi;
    logic [13:0] remain;
    logic [8:0]  rsvd_lo;
    logic        enc_pend;
    logic        burst_pend;
    logic        out_en;
    logic        rec_en;
    logic        running;
    logic [1:0]  pin_lvl;
  } mtc_status_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] diff;
  } mtc_ttd_t;

endpackage

//--- mtc_sync2.sv
// Two-flop synchroniser for one asynchronous level
`timescale 1ns/10ps
`default_nettype none
module mtc_sync2 (
  // Clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // Level
  input  wire logic d,
  output var  logic q
);
  logic meta_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_r <= 1'b0;
      q      <= 1'b0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule
`default_nettype wire

//--- mtc_trigger_ctrl.sv
// Measurement trigger control with AHB-Lite register slave
//
// Our own choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "mtc_consts.svh"
module mtc_trigger_ctrl
  import mtc_pkg::*;
(
  // Clock and reset
  input  wire logic             hclk,
  input  wire logic             hresetn,
  // AHB-Lite slave
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output var  logic [31:0]      hrdata,
  output var  logic             hreadyout,
  output var  logic             hresp,
  // Trigger pins and encoder positions
  input  wire logic             sync_trig_in,
  input  wire logic             aux_trigger_input,
  input  wire logic [2:0][31:0] enc_pos,
  // Measuring cycle and gating
  output var  logic             cycle_start,
  output var  logic             exposure_end,
  output var  logic             record_en,
  output var  logic             output_en,
  output var  logic [15:0]      trig_time_diff,
  output var  logic             trig_time_valid
);
  localparam int EXP_D = `MTC_EXP_OFFSET_CYC;

  // Bus state
  logic                   ap_take;
  logic                   dp_wr_r;
  logic [`MTC_ADDR_W-1:0] dp_addr_r;
  logic [31:0]            rd_mux;
  logic                   wr_ctrl;
  logic                   wr_count;
  logic                   wr_period;
  logic                   wr_cmd;
  logic                   wr_enc;
  logic                   cmd_start;
  logic                   cmd_stop;

  // Registers
  mtc_ctrl_t              ctrl_r;
  logic [13:0]            count_r;
  logic [15:0]            period_r;
  logic [31:0]            enc_low_r;
  logic [31:0]            enc_high_r;
  logic [31:0]            enc_step_r;
  mtc_status_t            status;

  // Cycle and trigger state
  logic [15:0]            period_eff;
  logic [15:0]            cyc_cnt_r;
  logic                   cyc_wrap;
  logic [1:0]             pin_lvl;
  logic [1:0]             pin_prev_r;
  logic                   ext_src;
  logic                   act_lvl;
  logic                   act_prev;
  logic                   act_rise;
  logic                   sw_ev;
  logic                   burst_mode;
  logic                   burst_set;
  logic                   burst_pend_r;
  logic                   start_req;
  logic                   burst_emit;
  mtc_state_t             state_r;
  logic [13:0]            remain_r;
  logic [13:0]            count_eff;
  logic                   enc_src;
  logic [1:0]             enc_idx;
  logic [31:0]            pos;
  logic [31:0]            enc_next_r;
  logic                   enc_hit;
  logic                   enc_pend_r;
  logic                   gate_now;
  logic                   trig_ev;
  logic                   ev_seen_r;
  logic [15:0]            ttd_cap_r;
  mtc_ttd_t               ttd_in;
  mtc_ttd_t               ttd_out;
  logic                   hreadyout_r;
  logic [31:0]            hrdata_r;

  // ---------------- AHB-Lite slave ----------------
  // Zero wait states: reads are muxed in the address phase, writes land in the data phase
  assign ap_take = hsel & htrans[1] & hready;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr_r   <= 1'b0;
      dp_addr_r <= '0;
    end else begin
      dp_wr_r   <= ap_take & hwrite;
      dp_addr_r <= haddr[`MTC_ADDR_W-1:0];
    end
  end

  assign wr_ctrl   = dp_wr_r && (dp_addr_r == `MTC_OFF_CTRL);
  assign wr_count  = dp_wr_r && (dp_addr_r == `MTC_OFF_COUNT);
  assign wr_period = dp_wr_r && (dp_addr_r == `MTC_OFF_PERIOD);
  assign wr_cmd    = dp_wr_r && (dp_addr_r == `MTC_OFF_CMD);
  assign wr_enc    = dp_wr_r && ((dp_addr_r == `MTC_OFF_ENC_LOW) || (dp_addr_r == `MTC_OFF_ENC_STEP));
  assign cmd_start = wr_cmd & hwdata[`MTC_CMD_START_BIT];
  assign cmd_stop  = wr_cmd & hwdata[`MTC_CMD_STOP_BIT];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r     <= `MTC_CTRL_RST;
      count_r    <= `MTC_COUNT_RST;
      period_r   <= `MTC_PERIOD_RST;
      enc_low_r  <= `MTC_ENC_LOW_RST;
      enc_high_r <= `MTC_ENC_HIGH_RST;
      enc_step_r <= `MTC_ENC_STEP_RST;
    end else if (dp_wr_r) begin
      if (wr_ctrl) begin
        ctrl_r      <= hwdata;
        ctrl_r.rsvd <= '0;
      end else if (wr_count) begin
        count_r <= hwdata[13:0];
      end else if (wr_period) begin
        period_r <= hwdata[15:0];
      end else if (dp_addr_r == `MTC_OFF_ENC_LOW) begin
        enc_low_r <= hwdata;
      end else if (dp_addr_r == `MTC_OFF_ENC_HIGH) begin
        enc_high_r <= hwdata;
      end else if (dp_addr_r == `MTC_OFF_ENC_STEP) begin
        enc_step_r <= hwdata;
      end
    end
  end

  always_comb begin
    status            = '0;
    status.pin_lvl    = pin_lvl;
    status.running    = (state_r == ST_RUN);
    status.rec_en     = record_en;
    status.out_en     = output_en;
    status.burst_pend = burst_pend_r;
    status.enc_pend   = enc_pend_r;
    status.remain     = remain_r;
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (haddr[`MTC_ADDR_W-1:0] == `MTC_OFF_CTRL) begin
      rd_mux = ctrl_r;
    end else if (haddr[`MTC_ADDR_W-1:0] == `MTC_OFF_COUNT) begin
      rd_mux = {18'h00000, count_r};
    end else if (haddr[`MTC_ADDR_W-1:0] == `MTC_OFF_PERIOD) begin
      rd_mux = {16'h0000, period_r};
    end else if (haddr[`MTC_ADDR_W-1:0] == `MTC_OFF_ENC_LOW) begin
      rd_mux = enc_low_r;
    end else if (haddr[`MTC_ADDR_W-1:0] == `MTC_OFF_ENC_HIGH) begin
      rd_mux = enc_high_r;
    end else if (haddr[`MTC_ADDR_W-1:0] == `MTC_OFF_ENC_STEP) begin
      rd_mux = enc_step_r;
    end else if (haddr[`MTC_ADDR_W-1:0] == `MTC_OFF_STATUS) begin
      rd_mux = status;
    end else if (haddr[`MTC_ADDR_W-1:0] == `MTC_OFF_TTD) begin
      rd_mux = {15'h0000, trig_time_valid, trig_time_diff};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r    <= 32'h0000_0000;
      hreadyout_r <= 1'b1;
      hresp       <= 1'b0;
    end else begin
      hreadyout_r <= 1'b1;
      hresp       <= 1'b0;
      if (ap_take && !hwrite) begin
        hrdata_r <= rd_mux;
      end
    end
  end

  assign hrdata    = hrdata_r;
  assign hreadyout = hreadyout_r;

  // ---------------- Measuring cycle ----------------
  // Too short a period would put the exposure end past the next cycle start
  assign period_eff = (period_r < `MTC_PERIOD_MIN) ? `MTC_PERIOD_MIN : period_r;
  assign cyc_wrap   = (cyc_cnt_r >= period_eff - 16'h0001);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cyc_cnt_r    <= 16'h0000;
      cycle_start  <= 1'b0;
      exposure_end <= 1'b0;
    end else begin
      // Free running whatever the trigger settings
      cyc_cnt_r    <= cyc_wrap ? 16'h0000 : cyc_cnt_r + 16'h0001;
      cycle_start  <= cyc_wrap;
      exposure_end <= (cyc_cnt_r == 16'(EXP_D - 1));
    end
  end

  // ---------------- Trigger inputs ----------------
  mtc_sync2 u_sync_main (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d       (sync_trig_in),
    .q       (pin_lvl[0])
  );

  mtc_sync2 u_sync_aux (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d       (aux_trigger_input),
    .q       (pin_lvl[1])
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_prev_r <= 2'b00;
    end else begin
      pin_prev_r <= pin_lvl;
    end
  end

  assign ext_src  = (ctrl_r.src == SRC_SYNC) || (ctrl_r.src == SRC_AUX);
  assign act_lvl  = ((ctrl_r.src == SRC_AUX) ? pin_lvl[1] : pin_lvl[0]) == ctrl_r.pol_high;
  assign act_prev = ((ctrl_r.src == SRC_AUX) ? pin_prev_r[1] : pin_prev_r[0]) == ctrl_r.pol_high;
  // No pulse filter: pulses are taken as long enough to survive the synchroniser
  assign act_rise = ext_src & act_lvl & ~act_prev;
  assign sw_ev    = (ctrl_r.src == SRC_SW) & cmd_start;

  // ---------------- Burst counting (edge and software) ----------------
  assign burst_mode = (ext_src & ctrl_r.edge_mode) | (ctrl_r.src == SRC_SW);
  assign burst_set  = (act_rise & ctrl_r.edge_mode) | sw_ev;
  assign start_req  = burst_pend_r | burst_set;
  assign count_eff  = (count_r == `MTC_COUNT_ZERO) ? `MTC_COUNT_ONE : count_r;
  assign burst_emit = (state_r == ST_RUN) | (burst_mode & start_req);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      burst_pend_r <= 1'b0;
    end else if (cmd_stop || wr_ctrl) begin
      // Stop beats a same-clock start; only the cycle boundary loses to a new event
      burst_pend_r <= 1'b0;
    end else if (burst_set) begin
      burst_pend_r <= 1'b1;
    end else if (cyc_wrap) begin
      burst_pend_r <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r  <= ST_IDLE;
      remain_r <= `MTC_COUNT_ZERO;
    end else if (cmd_stop || wr_ctrl) begin
      state_r  <= ST_IDLE;
      remain_r <= `MTC_COUNT_ZERO;
    end else if (cyc_wrap) begin
      case (state_r)
        ST_IDLE: begin
          if (burst_mode && start_req) begin
            if (ctrl_r.infinite || (count_eff > `MTC_COUNT_ONE)) begin
              state_r <= ST_RUN;
            end
            remain_r <= count_eff - `MTC_COUNT_ONE;
          end
        end
        ST_RUN: begin
          if (!ctrl_r.infinite) begin
            if (remain_r <= `MTC_COUNT_ONE) begin
              state_r <= ST_IDLE;
            end
            remain_r <= remain_r - `MTC_COUNT_ONE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ---------------- Encoder window ----------------
  // Only increasing positions step the window; moving back below the lower limit re-arms it
  assign enc_src = ctrl_r.src[2] & (ctrl_r.src[1:0] != 2'b11);
  assign enc_idx = ctrl_r.src[1:0];
  assign pos     = (enc_idx == 2'b11) ? 32'h0000_0000 : enc_pos[enc_idx];
  assign enc_hit = enc_src & (pos >= enc_next_r) & (pos >= enc_low_r) & (pos <= enc_high_r);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      enc_next_r <= `MTC_ENC_LOW_RST;
    end else if (wr_enc || wr_ctrl || (pos < enc_low_r)) begin
      enc_next_r <= enc_low_r;
    end else if (enc_hit) begin
      enc_next_r <= 32'(enc_next_r + enc_step_r);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      enc_pend_r <= 1'b0;
    end else if (enc_hit) begin
      enc_pend_r <= 1'b1;
    end else if (cyc_wrap) begin
      enc_pend_r <= 1'b0;
    end
  end

  // ---------------- Gate per measuring cycle ----------------
  always_comb begin
    gate_now = 1'b0;
    case (ctrl_r.src)
      SRC_INACT: gate_now = 1'b1;
      SRC_SYNC,
      SRC_AUX:   gate_now = ctrl_r.edge_mode ? burst_emit : act_lvl;
      SRC_SW:    gate_now = burst_emit;
      SRC_ENC0,
      SRC_ENC1,
      SRC_ENC2:  gate_now = enc_pend_r | enc_hit;
      default:   gate_now = 1'b0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      record_en <= 1'b1;
    end else if (cyc_wrap) begin
      // Output mode keeps computing so averages see values before the trigger
      record_en <= ctrl_r.mode_out ? 1'b1 : gate_now;
    end
  end

  // One gate feeds both analog and digital outputs, delayed by the processing latency
  mtc_cycle_pipe #(
    .WIDTH   (1),
    .DEPTH   (`MTC_PROC_DLY),
    .RST_VAL (1'b1)
  ) u_out_pipe (
    .hclk    (hclk),
    .hresetn (hresetn),
    .adv     (cyc_wrap),
    .din     (gate_now),
    .dout    (output_en)
  );

  // ---------------- Trigger time difference ----------------
  assign trig_ev = act_rise | sw_ev | enc_hit;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ev_seen_r <= 1'b0;
      ttd_cap_r <= 16'h0000;
    end else if (cyc_wrap) begin
      ev_seen_r <= 1'b0;
    end else if (trig_ev && !ev_seen_r) begin
      ev_seen_r <= 1'b1;
      ttd_cap_r <= cyc_cnt_r;
    end
  end

  assign ttd_in.valid = ev_seen_r | trig_ev;
  assign ttd_in.diff  = ev_seen_r ? ttd_cap_r : cyc_cnt_r;

  mtc_cycle_pipe #(
    .WIDTH   (17),
    .DEPTH   (`MTC_TTD_DLY),
    .RST_VAL (17'h00000)
  ) u_ttd_pipe (
    .hclk    (hclk),
    .hresetn (hresetn),
    .adv     (cyc_wrap),
    .din     (ttd_in),
    .dout    (ttd_out)
  );

  assign trig_time_valid = ttd_out.valid;
  assign trig_time_diff  = ttd_out.diff;

  // ---------------- Checks ----------------
  AST_RATE_FREE: assert property (@(posedge hclk) disable iff (!hresetn)
    !cyc_wrap |=> (cyc_cnt_r == $past(cyc_cnt_r) + 16'h0001) && !cycle_start)
    else $error("measuring cycle counter disturbed");

  AST_EXP_OFFSET: assert property (@(posedge hclk) disable iff (!hresetn)
    cycle_start |-> ##[EXP_D:EXP_D] exposure_end)
    else $error("exposure end not at fixed offset");

  AST_DEFAULT_CONT: assert property (@(posedge hclk) disable iff (!hresetn)
    (cyc_wrap && ctrl_r.src == SRC_INACT) |=> record_en && cycle_start)
    else $error("inactive source did not record continuously");

  AST_LEVEL_GATE: assert property (@(posedge hclk) disable iff (!hresetn)
    (cyc_wrap && ext_src && !ctrl_r.edge_mode && !ctrl_r.mode_out) |=> (record_en == $past(act_lvl)))
    else $error("level gate does not follow active level");

  AST_BURST_END: assert property (@(posedge hclk) disable iff (!hresetn)
    (cyc_wrap && state_r == ST_RUN && !ctrl_r.infinite && remain_r == `MTC_COUNT_ONE)
      |=> state_r == ST_IDLE && remain_r == `MTC_COUNT_ZERO)
    else $error("burst ran past its count");

  AST_SW_START: assert property (@(posedge hclk) disable iff (!hresetn)
    (sw_ev && !cmd_stop && !cyc_wrap && state_r == ST_IDLE) |=> burst_pend_r)
    else $error("software start lost");

  AST_STOP: assert property (@(posedge hclk) disable iff (!hresetn)
    cmd_stop |=> (state_r == ST_IDLE) && !burst_pend_r)
    else $error("stop command did not end output");

  AST_ENC_WINDOW: assert property (@(posedge hclk) disable iff (!hresetn)
    (enc_hit && !wr_enc && !wr_ctrl) |=> (enc_next_r == $past(enc_next_r) + $past(enc_step_r)) && enc_pend_r)
    else $error("encoder window did not step after a hit");

  AST_REC_GATE: assert property (@(posedge hclk) disable iff (!hresetn)
    (cyc_wrap && !ctrl_r.mode_out && ctrl_r.src == SRC_SW) |=> (record_en == $past(burst_emit)))
    else $error("record mode computed without trigger");

  AST_OUT_MODE_REC: assert property (@(posedge hclk) disable iff (!hresetn)
    (cyc_wrap && ctrl_r.mode_out) |=> record_en)
    else $error("output mode stopped computing");

  AST_OUT_DELAY: assert property (@(posedge hclk) disable iff (!hresetn)
    $changed(output_en) |-> $past(cyc_wrap))
    else $error("output gate moved off a cycle boundary");

  AST_TTD_LATE: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(ev_seen_r) && !cyc_wrap |-> !trig_time_valid || $stable(trig_time_diff))
    else $error("trigger time difference appeared too early");
endmodule
`default_nettype wire
